// file: verilog/pcs_sequencer.sv
// Purpose: Press cycle sequencer with Wishbone config
// Assumes: All inputs synchronous to clk_i
// Notes: Valve outputs are registered from the next state
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module pcs_sequencer (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Guards, operator controls, sensors
  input  wire logic        estop_ok_i,
  input  wire logic        guard_ok_i,
  input  wire logic        op_reset_i,
  input  wire logic        go_i,
  input  wire logic        pedal_input_i,
  input  wire logic        part_present_input_i,
  input  wire logic        sequential_stop_input_i,
  input  wire logic        mute_sensor_input_i,
  input  wire logic        top_position_input_i,
  input  wire logic        bottom_position_input_i,
  // Valves and status
  output logic             up_o,
  output logic             down_o,
  output logic             high_o,
  output logic             low_o,
  output logic             guard_muted_o
);

  // State registers
  pcs_pkg::pcs_cfg_t   cfg_q;
  pcs_pkg::pcs_cfg_t   cfg_d;
  pcs_pkg::pcs_state_t st_q;
  pcs_pkg::pcs_state_t st_d;
  pcs_pkg::pcs_stat_t  stat;
  logic        cfg_err_q;
  logic        cfg_err_d;
  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic        armed_q;
  logic        armed_d;
  logic        go_q;
  logic        pedal_q;
  logic        pip_ok_q;
  logic        pip_ok_d;
  logic        pip_low_q;
  logic        pip_low_d;
  logic        up_q;
  logic        up_d;
  logic        down_q;
  logic        down_d;
  logic        high_q;
  logic        high_d;
  logic        low_q;
  logic        low_d;

  // Effective options
  logic        pip_en;
  logic        sqs_en;
  logic        mg_en;
  logic        ped_en;
  logic        ms_en;
  logic        dual_en;
  logic        go_rise;
  logic        ped_rise;
  logic        muted;
  logic        stop_all;
  logic        can_start;
  logic        bus_req;
  logic        wr_cfg;
  pcs_pkg::pcs_cfg_t wcfg;

  // Press inputs block gates the default inputs
  assign pip_en = cfg_q.pci & cfg_q.part_present_input;
  assign sqs_en = cfg_q.pci & cfg_q.sequential_stop_input;
  assign mg_en  = cfg_q.pci & cfg_q.mguard;

  // Options that exist only with the stop point
  assign ped_en  = sqs_en & cfg_q.pedal;
  assign ms_en   = sqs_en & cfg_q.msens;
  assign dual_en = sqs_en & cfg_q.dual;

  // Edges of operator requests
  assign go_rise  = go_i & ~go_q;
  assign ped_rise = pedal_input_i & ~pedal_q;

  // Guard muting from the current position in the cycle
  always_comb begin
    muted = 1'b0;
    if (mg_en) begin
      case (st_q)
        pcs_pkg::ST_HOLD: muted = 1'b1;
        pcs_pkg::ST_DBOT: muted = 1'b1;
        pcs_pkg::ST_ABOT: muted = 1'b1;
        pcs_pkg::ST_UP:   muted = cfg_q.single;
        default:          muted = 1'b0;
      endcase
    end
  end

  // Estop and unmuted guard: turn-off authority in every motion state
  assign stop_all = ~estop_ok_i | (~guard_ok_i & ~muted);

  // Start needs armed guards, top, part and fresh request
  // A guard or estop dropping in the start cycle still refuses the start
  assign can_start = armed_q & ~stop_all & top_position_input_i & go_rise
                   & (~pip_en | (part_present_input_i & pip_ok_q));

  // Arming by operator reset while guards are in Run
  always_comb begin
    armed_d = armed_q;
    if (stop_all) begin
      armed_d = 1'b0;
    end else if (op_reset_i) begin
      armed_d = 1'b1;
    end
  end

  // Part sensor must toggle after the slide leaves bottom
  always_comb begin
    pip_ok_d  = pip_ok_q;
    pip_low_d = pip_low_q;
    if (st_q == pcs_pkg::ST_DBOT && bottom_position_input_i) begin
      pip_ok_d  = 1'b0;
      pip_low_d = 1'b0;
    end else if (!bottom_position_input_i && !pip_ok_q) begin
      if (!part_present_input_i) begin
        pip_low_d = 1'b1;
      end else if (pip_low_q) begin
        pip_ok_d = 1'b1;
      end
    end
  end

  // Sequencer next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      pcs_pkg::ST_IDLE: begin
        if (can_start) begin
          st_d = sqs_en ? pcs_pkg::ST_DSQS : pcs_pkg::ST_DBOT;
        end
      end
      pcs_pkg::ST_DSQS: begin
        if (cfg_q.manual && !go_i) begin
          st_d = pcs_pkg::ST_HALT;
        end else if (sequential_stop_input_i) begin
          if (!ms_en || mute_sensor_input_i) begin
            st_d = pcs_pkg::ST_HOLD;
          end else begin
            st_d = pcs_pkg::ST_HALT;
          end
        end
      end
      pcs_pkg::ST_HOLD: begin
        if (ped_en) begin
          if (ped_rise) begin
            st_d = pcs_pkg::ST_DBOT;
          end
        end else if (go_rise) begin
          st_d = pcs_pkg::ST_DBOT;
        end
      end
      pcs_pkg::ST_DBOT: begin
        if (ped_en && !pedal_input_i) begin
          st_d = pcs_pkg::ST_HALT;
        end else if (!ped_en && cfg_q.manual && !go_i) begin
          st_d = pcs_pkg::ST_HALT;
        end else if (bottom_position_input_i) begin
          // Pedal stroke stops at bottom, others return
          if (ped_en) begin
            st_d = pcs_pkg::ST_ABOT;
          end else begin
            st_d = pcs_pkg::ST_UP;
          end
        end
      end
      pcs_pkg::ST_ABOT: begin
        if (!pedal_input_i && go_rise) begin
          st_d = pcs_pkg::ST_UP;
        end
      end
      pcs_pkg::ST_UP: begin
        if (top_position_input_i) begin
          st_d = pcs_pkg::ST_IDLE;
        end else if (cfg_q.manual && !go_i) begin
          st_d = pcs_pkg::ST_HALT;
        end
      end
      pcs_pkg::ST_HALT: begin
        if (top_position_input_i && !go_i) begin
          st_d = pcs_pkg::ST_IDLE;
        end else if (armed_q && go_rise && !top_position_input_i) begin
          st_d = pcs_pkg::ST_UP;
        end
      end
      default: st_d = pcs_pkg::ST_HALT;
    endcase
    // Unmuted guard or estop loss overrides every motion state
    if (stop_all && st_q != pcs_pkg::ST_IDLE) begin
      st_d = pcs_pkg::ST_HALT;
    end
  end

  // Valve outputs decoded from next state
  always_comb begin
    up_d   = 1'b0;
    down_d = 1'b0;
    high_d = 1'b0;
    low_d  = 1'b0;
    case (st_d)
      pcs_pkg::ST_DSQS: begin
        down_d = 1'b1;
        low_d  = dual_en;
      end
      pcs_pkg::ST_DBOT: begin
        down_d = 1'b1;
        high_d = dual_en;
      end
      pcs_pkg::ST_UP: begin
        up_d  = 1'b1;
        low_d = dual_en;
      end
      default: begin
        up_d = 1'b0;
      end
    endcase
  end

  // Wishbone decode; config write lands on the edge the master sees ack
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_cfg  = bus_req & wb_we_i & ack_q & (wb_adr_i == pcs_pkg::ADR_CFG);

  // Byte lanes merged into the config word
  always_comb begin
    wcfg = cfg_q;
    if (wb_sel_i[0]) begin
      wcfg[7:0] = wb_dat_i[7:0];
    end
    if (wb_sel_i[1]) begin
      wcfg[8] = wb_dat_i[8];
    end
  end

  // Config update, conflicting modes refused
  always_comb begin
    cfg_d     = cfg_q;
    cfg_err_d = cfg_err_q;
    if (wr_cfg) begin
      if (wcfg.manual && wcfg.single) begin
        cfg_err_d = 1'b1;
      end else begin
        cfg_d     = wcfg;
        cfg_err_d = 1'b0;
      end
    end
  end

  // Status word
  always_comb begin
    stat.state   = st_q;
    stat.up      = up_q;
    stat.down    = down_q;
    stat.high    = high_q;
    stat.low     = low_q;
    stat.muted   = muted;
    stat.armed   = armed_q;
    stat.pip_ok  = pip_ok_q;
    stat.cfg_err = cfg_err_q;
  end

  // Ack one cycle after request, read data registered
  always_comb begin
    ack_d  = bus_req & ~ack_q;
    rdat_d = 32'h0000_0000;
    if (bus_req && !ack_q && !wb_we_i) begin
      case (wb_adr_i)
        pcs_pkg::ADR_CFG:  rdat_d = {23'h000000, cfg_q};
        pcs_pkg::ADR_STAT: rdat_d = {21'h000000, stat};
        default:           rdat_d = 32'h0000_0000;
      endcase
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q     <= pcs_pkg::CFG_RST;
      cfg_err_q <= 1'b0;
      ack_q     <= 1'b0;
      rdat_q    <= 32'h0000_0000;
      st_q      <= pcs_pkg::ST_HALT;
      armed_q   <= 1'b0;
      go_q      <= 1'b1;
      pedal_q   <= 1'b1;
      pip_ok_q  <= 1'b1;
      pip_low_q <= 1'b0;
      up_q      <= 1'b0;
      down_q    <= 1'b0;
      high_q    <= 1'b0;
      low_q     <= 1'b0;
    end else begin
      cfg_q     <= cfg_d;
      cfg_err_q <= cfg_err_d;
      ack_q     <= ack_d;
      rdat_q    <= rdat_d;
      st_q      <= st_d;
      armed_q   <= armed_d;
      go_q      <= go_i;
      pedal_q   <= pedal_input_i;
      pip_ok_q  <= pip_ok_d;
      pip_low_q <= pip_low_d;
      up_q      <= up_d;
      down_q    <= down_d;
      high_q    <= high_d;
      low_q     <= low_d;
    end
  end

  // Outputs
  assign wb_ack_o      = ack_q;
  assign wb_dat_o      = rdat_q;
  assign up_o          = up_q;
  assign down_o        = down_q;
  assign high_o        = high_q;
  assign low_o         = low_q;
  assign guard_muted_o = muted;

endmodule
`default_nettype wire

// file: verilog/pcs_pkg.sv
// Purpose: Constants and types for the press cycle sequencer
// Assumes: Classic Wishbone, 32-bit data, byte addresses
// Notes on behaviour
// - Start only while part present
// - Part sensor must toggle after leaving bottom
// - Press inputs default: part, stop, guard
// - Pedal, mute sensor, dual need stop
// - Pedal at stop point drives to bottom
// - Two-hand, pedal to bottom, two-hand up
// - Pedal on start: stop, then stroke to bottom only
// - No pedal: two-hand again finishes stroke
// - Mute sensor mutes guard at safe point
// - Dual pressure adds high, low outputs
// - High pressure after stop point
// - Low pressure to stop point, upstroke
// - Single: estop, guard, top armed first
// - Single: estop, guard, top turn off
// - Manual: estop, guard, part, top first
// - First down: estop, guard, release, stop
// - At stop point halt and mute guard
// - Second down: estop, pedal, bottom stop
// - From bottom, two-hand returns slide up
// - Upstroke: release, estop, guard, top stop
// - Single: start request is momentary
// - Manual and single never both set
// - Single: guard muted whole upstroke
package pcs_pkg;

  // Register byte addresses
  localparam logic [7:0] ADR_CFG  = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;

  // Configuration word, bit 0 is press inputs enable
  typedef struct packed {
    logic single;
    logic manual;
    logic dual;
    logic msens;
    logic pedal;
    logic mguard;
    logic sequential_stop_input;
    logic part_present_input;
    logic pci;
  } pcs_cfg_t;

  // Press inputs on with part, stop, guard; manual
  localparam pcs_cfg_t CFG_RST = 9'h08F;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DSQS = 3'b001,
    ST_HOLD = 3'b010,
    ST_DBOT = 3'b011,
    ST_ABOT = 3'b100,
    ST_UP   = 3'b101,
    ST_HALT = 3'b110
  } pcs_state_t;

  // Status word, low bits first from the right
  typedef struct packed {
    logic       cfg_err;
    logic       pip_ok;
    logic       armed;
    logic       muted;
    logic       low;
    logic       high;
    logic       down;
    logic       up;
    pcs_state_t state;
  } pcs_stat_t;

endpackage

// file: verif/pcs_props.sv
// Purpose: Port assertions for the press sequencer
// Assumes: Stop point, mute sensor and guard muting enabled
// Notes: Bound to every sequencer instance
`timescale 1ns/1ps
`default_nettype none
module pcs_props (
  // Clock, reset and sensors
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic estop_ok_i,
  input wire logic guard_ok_i,
  input wire logic sequential_stop_input_i,
  input wire logic mute_sensor_input_i,
  input wire logic top_position_input_i,
  input wire logic bottom_position_input_i,
  // Valves
  input wire logic up_o,
  input wire logic down_o,
  input wire logic high_o,
  input wire logic low_o,
  input wire logic guard_muted_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Motion valves and their stop causes
  chk_updown_excl: assert property (!(up_o && down_o))
    else $error("up and down on together");
  chk_estop_off: assert property (!estop_ok_i |=> !(up_o || down_o))
    else $error("estop left motion on");
  chk_guard_off: assert property (!guard_ok_i && !guard_muted_o |=> !(up_o || down_o))
    else $error("guard left motion on");
  chk_stop_halt: assert property (down_o && $rose(sequential_stop_input_i) |=> !down_o)
    else $error("stop point did not halt");
  chk_stop_mute: assert property (down_o && $rose(sequential_stop_input_i)
    && mute_sensor_input_i |=> guard_muted_o)
    else $error("guard not muted at stop point");
  chk_bottom_stop: assert property (down_o && bottom_position_input_i |=> !down_o)
    else $error("bottom did not stop down");
  chk_top_stop: assert property (up_o && top_position_input_i |=> !up_o)
    else $error("top did not stop up");
  chk_high_down: assert property (high_o |-> down_o && !low_o)
    else $error("high without down");
  chk_low_motion: assert property (low_o |-> up_o || down_o)
    else $error("low without motion");
  // Main scenarios reached
  cov_muted: cover property ($rose(guard_muted_o));
  cov_high: cover property ($rose(high_o));
  cov_up: cover property ($rose(up_o));
endmodule
bind pcs_sequencer pcs_props u_props (.clk_i(clk_i), .rst_i(rst_i), .estop_ok_i(estop_ok_i),
  .guard_ok_i(guard_ok_i), .sequential_stop_input_i(sequential_stop_input_i),
  .mute_sensor_input_i(mute_sensor_input_i), .top_position_input_i(top_position_input_i),
  .bottom_position_input_i(bottom_position_input_i), .up_o(up_o), .down_o(down_o),
  .high_o(high_o), .low_o(low_o), .guard_muted_o(guard_muted_o));
`default_nettype wire

// file: verif/pcs_press_model.sv
// Purpose: Slide model giving position sensors from valves
// Assumes: One position step per clock while a valve is on
// Notes: Stop and mute sensors stay on below the stop point
`timescale 1ns/1ps
`default_nettype none
module pcs_press_model #(
  parameter int SQ  = 5,
  parameter int BOT = 12
) (
  // Clock, reset, valves
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic up_i,
  input  wire logic down_i,
  // Sensors
  output logic      top_o,
  output logic      bottom_o,
  output logic      sqs_o,
  output logic      mute_o
);
  logic [3:0] pos_q;
  logic [3:0] pos_d;
  // Slide travel
  always_comb begin
    pos_d = pos_q;
    if (down_i && pos_q < 4'(BOT)) pos_d = pos_q + 4'h1;
    if (up_i && pos_q != 4'h0) pos_d = pos_q - 4'h1;
  end
  always_ff @(posedge clk_i) begin
    pos_q <= rst_i ? 4'h0 : pos_d;
  end
  // Sensors from position
  assign top_o    = (pos_q == 4'h0);
  assign bottom_o = (pos_q == 4'(BOT));
  assign sqs_o    = (pos_q >= 4'(SQ));
  assign mute_o   = sqs_o;
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Purpose: Self-checking bench for the press sequencer
// Assumes: Manual stroke with pedal, then single stroke without pedal, both with dual pressure
// Notes: Sensors come from the slide model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module testbench;
  // Bench signals
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat, q;
  logic        ack, estop = 1'b1, guard = 1'b1, opr = 1'b0, go = 1'b0;
  logic        pedal = 1'b0, part = 1'b0, sequential_stop_input, mute, top, bot, up, down, high, low, muted;
  int          miscompares = 0, total_checks = 0, cycles = 0;
  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;
  pcs_sequencer DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .estop_ok_i(estop), .guard_ok_i(guard), .op_reset_i(opr), .go_i(go),
    .pedal_input_i(pedal), .part_present_input_i(part), .sequential_stop_input_i(sequential_stop_input),
    .mute_sensor_input_i(mute), .top_position_input_i(top), .bottom_position_input_i(bot),
    .up_o(up), .down_o(down), .high_o(high), .low_o(low), .guard_muted_o(muted));
  pcs_press_model u_slide (.clk_i(clk_i), .rst_i(rst_i), .up_i(up), .down_i(down),
    .top_o(top), .bottom_o(bot), .sqs_o(sequential_stop_input), .mute_o(mute));
  // Classic cycle held until ack, read data into q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Poll status until the state shows up
  task automatic st(input pcs_pkg::pcs_state_t s);
    int n = 0;
    do begin
      wb(1'b0, pcs_pkg::ADR_STAT, 32'h0);
      n++;
    end while (q[2:0] !== s && n < 60);
    `CHK("state", s, q[2:0])
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang limit
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, pcs_pkg::ADR_CFG, 32'h0);
    `CHK("cfg reset", 32'h0000008F, q)
    wb(1'b1, pcs_pkg::ADR_CFG, 32'h00000180);
    wb(1'b0, pcs_pkg::ADR_STAT, 32'h0);
    `CHK("cfg_err", 1'b1, q[10])
    wb(1'b1, pcs_pkg::ADR_CFG, 32'h000000FF);
    wb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 32'h0, q)
    wb(1'b0, pcs_pkg::ADR_CFG, 32'h0);
    `CHK("cfg", 32'h000000FF, q)
    st(pcs_pkg::ST_IDLE);
    @(posedge clk_i) guard <= 1'b0;
    @(posedge clk_i) guard <= 1'b1;
    @(posedge clk_i) opr <= 1'b1;
    @(posedge clk_i) opr <= 1'b0;
    part <= 1'b1;
    go   <= 1'b1;
    st(pcs_pkg::ST_HOLD);
    `CHK("muted", 1'b1, muted)
    guard <= 1'b0;
    go    <= 1'b0;
    st(pcs_pkg::ST_HOLD);
    guard <= 1'b1;
    @(posedge clk_i) pedal <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK("down", 1'b1, down)
    `CHK("high", 1'b1, high)
    st(pcs_pkg::ST_ABOT);
    pedal <= 1'b0;
    go    <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK("up", 1'b1, up)
    `CHK("low", 1'b1, low)
    st(pcs_pkg::ST_IDLE);
    go <= 1'b0;
    @(posedge clk_i) go <= 1'b1;
    repeat (4) @(posedge clk_i);
    `CHK("down", 1'b0, down)
    go <= 1'b0;
    @(posedge clk_i) part <= 1'b0;
    @(posedge clk_i) part <= 1'b1;
    @(posedge clk_i) go <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK("down", 1'b1, down)
    estop <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK("down", 1'b0, down)
    st(pcs_pkg::ST_HALT);
    // Recover from halt, then one single stroke without pedal
    estop <= 1'b1;
    go    <= 1'b0;
    @(posedge clk_i) opr <= 1'b1;
    @(posedge clk_i) opr <= 1'b0;
    @(posedge clk_i) go <= 1'b1;
    st(pcs_pkg::ST_IDLE);
    go <= 1'b0;
    wb(1'b1, pcs_pkg::ADR_CFG, 32'h0000016F);
    @(posedge clk_i) go <= 1'b1;
    @(posedge clk_i) go <= 1'b0;
    st(pcs_pkg::ST_HOLD);
    @(posedge clk_i) go <= 1'b1;
    @(posedge clk_i) go <= 1'b0;
    st(pcs_pkg::ST_UP);
    `CHK("up", 1'b1, up)
    `CHK("muted", 1'b1, muted)
    st(pcs_pkg::ST_IDLE);
    print_verdict();
  end
endmodule
`default_nettype wire
